// ==== verilog/cdcr_params.svh ====
// Purpose: Offsets, field positions and reset values of the card/device control bank
// Assumes: 32-bit AXI4-Lite data, registers in the low byte of each word
// Notes:   Printed offsets are register indexes; byte address is four times the index
`ifndef CDCR_PARAMS_SVH
`define CDCR_PARAMS_SVH

`define CDCR_IDX_CARD_CTRL  8'h91
`define CDCR_IDX_DEV_CTRL   8'h92
`define CDCR_ADDR_CARD_CTRL 12'h244
`define CDCR_ADDR_DEV_CTRL  12'h248
`define CDCR_ADDR_IRQ_STAT  12'h300
`define CDCR_ADDR_IRQ_MASK  12'h304
`define CDCR_ADDR_SKT_PWR   12'h308
`define CDCR_ADDR_SKT_STAT  12'h30c

`define CDCR_RST_CARD_CTRL  8'h00
`define CDCR_RST_DEV_CTRL   8'h66
`define CDCR_DEV_WR_MASK    8'hef
`define CDCR_RST_SYNC       5'h10

`define CDCR_CC_RING        7
`define CDCR_CC_AUDIO       2
`define CDCR_CC_SPK         1
`define CDCR_CC_FLAG        0
`define CDCR_DC_LOCK        7
`define CDCR_DC_LV          6
`define CDCR_DC_RSVD        4
`define CDCR_DC_MODE_LSB    1

`define CDCR_MULTIFUNCTION_TERMINAL_AUDIO    4'h8
`define CDCR_EV_CARD        0
`define CDCR_EV_PWR_REFUSED 1
`define CDCR_EV_W           2

`define CDCR_SY_CARD_IRQ    0
`define CDCR_SY_RING        1
`define CDCR_SY_SPK         2
`define CDCR_SY_AUDIO       3
`define CDCR_SY_GLOBAL_RESET_PIN        4

`define CDCR_RESP_OKAY      2'h0
`define CDCR_RESP_SLVERR    2'h2

`endif

// ==== verilog/cdcr_pkg.sv ====
// Purpose: Types of the card/device control bank
// Assumes: Nothing beyond SystemVerilog
// Notes:   Constants live in cdcr_params.svh
package cdcr_pkg;

  typedef enum logic [1:0] {
    CDCR_MODE_PARALLEL = 2'h0,
    CDCR_MODE_RSVD     = 2'h1,
    CDCR_MODE_SER_PAR  = 2'h2,
    CDCR_MODE_SERIAL   = 2'h3
  } cdcr_interrupt_signaling_select_t;

  typedef enum logic [2:0] {
    CDCR_SEL_NONE,
    CDCR_SEL_CARD,
    CDCR_SEL_DEV,
    CDCR_SEL_ISTAT,
    CDCR_SEL_IMASK,
    CDCR_SEL_SKTPWR,
    CDCR_SEL_SKTSTAT
  } cdcr_sel_t;

endpackage

// ==== verilog/cdcr_regs.sv ====
// Purpose: Card control and device control registers behind an AXI4-Lite slave
// Assumes: aclk 200 MHz; global_reset_n is an asynchronous pin, synchronised here
// Notes:   Sticky bits follow only the global reset pin, never aresetn
//
// Local design decision: the AXI4-Lite slave port.
`include "cdcr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cdcr_regs
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  global_reset_n,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  card_func_irq,
  input  wire logic                  card_ring_in,
  input  wire logic                  card_speaker_in,
  input  wire logic                  card_audio_in,
  input  wire logic                  d3_state,
  input  wire logic [3:0]            multifunction_terminal_route_code,
  output logic                       ring_indicate_output,
  output logic                       ring_indicate_oe_n,
  output logic                       speaker_output_pin,
  output logic                       speaker_output_oe_n,
  output logic                       multifunction_terminal,
  output logic                       multifunction_oe_n,
  output logic                       socket_power_on,
  output logic                       low_voltage_capable,
  output cdcr_pkg::cdcr_interrupt_signaling_select_t    interrupt_signaling_select,
  output logic                       irq
);
  import cdcr_pkg::*;

  logic [4:0]             sync1_q;
  logic [4:0]             sync2_q;
  logic                   global_reset_pin_n;
  logic [7:0]             card_ctrl_q;
  logic [7:0]             dev_ctrl_q;
  logic [`CDCR_EV_W-1:0]  istat_q;
  logic [`CDCR_EV_W-1:0]  imask_q;
  logic                   skt_pwr_q;
  logic [ADDR_W-1:0]      awaddr_q;
  logic                   aw_hold_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   w_hold_q;
  logic                   wr_go;
  cdcr_sel_t              wr_sel;
  cdcr_sel_t              rd_sel;
  logic                   rd_go;
  logic                   card_set;
  logic                   flag_clr;
  logic                   pwr_off_req;
  logic                   pwr_refused;
  logic [`CDCR_EV_W-1:0]  events;

  function automatic cdcr_sel_t dec(input logic [ADDR_W-1:0] a);
    case (a)
      `CDCR_ADDR_CARD_CTRL: dec = CDCR_SEL_CARD;
      `CDCR_ADDR_DEV_CTRL:  dec = CDCR_SEL_DEV;
      `CDCR_ADDR_IRQ_STAT:  dec = CDCR_SEL_ISTAT;
      `CDCR_ADDR_IRQ_MASK:  dec = CDCR_SEL_IMASK;
      `CDCR_ADDR_SKT_PWR:   dec = CDCR_SEL_SKTPWR;
      `CDCR_ADDR_SKT_STAT:  dec = CDCR_SEL_SKTSTAT;
      default:              dec = CDCR_SEL_NONE;
    endcase
  endfunction

  // Pin synchronisers
  // No bus reset here: a reset value
  // Would mask the global reset pin
  always_ff @(posedge aclk)
  begin
    sync1_q <= {global_reset_n, card_audio_in, card_speaker_in, card_ring_in, card_func_irq};
    sync2_q <= sync1_q;
  end

  assign global_reset_pin_n = sync2_q[`CDCR_SY_GLOBAL_RESET_PIN];

  // Write channel capture
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_sel = dec(awaddr_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CDCR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == CDCR_SEL_NONE) ? `CDCR_RESP_SLVERR : `CDCR_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read channel
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_sel = dec(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `CDCR_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `CDCR_RESP_OKAY;
      case (rd_sel)
        CDCR_SEL_CARD:    s_axi_rdata <= {24'h0, card_ctrl_q};
        CDCR_SEL_DEV:     s_axi_rdata <= {24'h0, dev_ctrl_q & `CDCR_DEV_WR_MASK};
        CDCR_SEL_ISTAT:   s_axi_rdata <= {30'h0, istat_q};
        CDCR_SEL_IMASK:   s_axi_rdata <= {30'h0, imask_q};
        CDCR_SEL_SKTPWR:  s_axi_rdata <= {31'h0, skt_pwr_q};
        CDCR_SEL_SKTSTAT: s_axi_rdata <= {30'h0, d3_state, skt_pwr_q};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `CDCR_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  assign card_set = sync2_q[`CDCR_SY_CARD_IRQ];
  assign flag_clr = wr_go && wr_sel == CDCR_SEL_CARD && wstrb_q[0] && wdata_q[`CDCR_CC_FLAG];

  // sticky bits follow global reset only
  always_ff @(posedge aclk)
  begin
    if (!global_reset_pin_n)
    begin
      card_ctrl_q <= `CDCR_RST_CARD_CTRL;
      dev_ctrl_q  <= `CDCR_RST_DEV_CTRL;
    end
    else
    begin
      if (wr_go && wr_sel == CDCR_SEL_CARD && wstrb_q[0])
        card_ctrl_q[7:1] <= wdata_q[7:1];
      if (card_set)
        card_ctrl_q[`CDCR_CC_FLAG] <= 1'b1;
      else if (flag_clr)
        card_ctrl_q[`CDCR_CC_FLAG] <= 1'b0;
      if (wr_go && wr_sel == CDCR_SEL_DEV && wstrb_q[0])
        dev_ctrl_q <= wdata_q[7:0] & `CDCR_DEV_WR_MASK;
    end
  end

  assign pwr_off_req = wr_go && wr_sel == CDCR_SEL_SKTPWR && wstrb_q[0] && !wdata_q[0];
  assign pwr_refused = pwr_off_req && dev_ctrl_q[`CDCR_DC_LOCK] && d3_state;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      skt_pwr_q <= 1'b1;
    else if (wr_go && wr_sel == CDCR_SEL_SKTPWR && wstrb_q[0] && !pwr_refused)
      skt_pwr_q <= wdata_q[0];
  end

  // Interrupt status, cleared by read
  assign events = {pwr_refused, card_set && !card_ctrl_q[`CDCR_CC_FLAG]};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      istat_q <= '0;
      imask_q <= '0;
      irq     <= 1'b0;
    end
    else
    begin
      istat_q <= ((rd_go && rd_sel == CDCR_SEL_ISTAT) ? '0 : istat_q) | events;
      if (wr_go && wr_sel == CDCR_SEL_IMASK && wstrb_q[0])
        imask_q <= wdata_q[`CDCR_EV_W-1:0];
      irq <= |(istat_q & imask_q);
    end
  end

  // Pin and control outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ring_indicate_output       <= 1'b0;
      ring_indicate_oe_n         <= 1'b1;
      speaker_output_pin         <= 1'b0;
      speaker_output_oe_n        <= 1'b1;
      multifunction_terminal     <= 1'b0;
      multifunction_oe_n         <= 1'b1;
      socket_power_on            <= 1'b1;
      low_voltage_capable        <= 1'b1;
      interrupt_signaling_select <= CDCR_MODE_SERIAL;
    end
    else
    begin
      ring_indicate_output <= sync2_q[`CDCR_SY_RING] && card_ctrl_q[`CDCR_CC_RING];
      ring_indicate_oe_n   <= !card_ctrl_q[`CDCR_CC_RING];
      speaker_output_pin   <= sync2_q[`CDCR_SY_SPK] && card_ctrl_q[`CDCR_CC_SPK];
      speaker_output_oe_n  <= !card_ctrl_q[`CDCR_CC_SPK];
      if (!card_ctrl_q[`CDCR_CC_AUDIO] && multifunction_terminal_route_code == `CDCR_MULTIFUNCTION_TERMINAL_AUDIO)
      begin
        multifunction_terminal <= sync2_q[`CDCR_SY_AUDIO];
        multifunction_oe_n     <= 1'b0;
      end
      else
      begin
        multifunction_terminal <= 1'b0;
        multifunction_oe_n     <= 1'b1;
      end
      socket_power_on <= skt_pwr_q;
      low_voltage_capable <= dev_ctrl_q[`CDCR_DC_LV];
      interrupt_signaling_select <= cdcr_interrupt_signaling_select_t'(dev_ctrl_q[`CDCR_DC_MODE_LSB +: 2]);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !global_reset_pin_n);

  property p_ring;
    card_ctrl_q[`CDCR_CC_RING] == 1'b0 |=> ring_indicate_oe_n && !ring_indicate_output;
  endproperty
  a_ring: assert property (p_ring) else $error("ring pin driven while disabled");

  property p_audio;
    !card_ctrl_q[`CDCR_CC_AUDIO] && multifunction_terminal_route_code == `CDCR_MULTIFUNCTION_TERMINAL_AUDIO
      |=> !multifunction_oe_n && multifunction_terminal == $past(sync2_q[`CDCR_SY_AUDIO]);
  endproperty
  a_audio: assert property (p_audio) else $error("card audio not on terminal");

  property p_route;
    multifunction_terminal_route_code != `CDCR_MULTIFUNCTION_TERMINAL_AUDIO |=> multifunction_oe_n;
  endproperty
  a_route: assert property (p_route) else $error("terminal driven with wrong code");

  property p_spk;
    !speaker_output_oe_n |-> speaker_output_pin == $past(sync2_q[`CDCR_SY_SPK]);
  endproperty
  a_spk: assert property (p_spk) else $error("speaker pin not following card");

  property p_flag_set;
    card_set |=> card_ctrl_q[`CDCR_CC_FLAG];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("card flag not set");

  property p_flag_clr;
    wr_go && wr_sel == CDCR_SEL_CARD && wstrb_q[0] && !card_set
      |=> card_ctrl_q[`CDCR_CC_FLAG] == ($past(card_ctrl_q[`CDCR_CC_FLAG]) && !$past(flag_clr));
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("card flag write wrong");

  property p_sticky;
    @(posedge aclk) disable iff (!global_reset_pin_n) !aresetn |=> $stable(card_ctrl_q) && $stable(dev_ctrl_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky bits changed by bus reset");

  property p_lock;
    pwr_off_req && dev_ctrl_q[`CDCR_DC_LOCK] && d3_state && skt_pwr_q |=> ##1 socket_power_on;
  endproperty
  a_lock: assert property (p_lock) else $error("locked socket powered down");

  property p_lv;
    $changed(dev_ctrl_q[`CDCR_DC_LV]) |=> low_voltage_capable == $past(dev_ctrl_q[`CDCR_DC_LV]);
  endproperty
  a_lv: assert property (p_lv) else $error("3-V report wrong");

  property p_rsvd4;
    rd_go && rd_sel == CDCR_SEL_DEV
      |=> !s_axi_rdata[`CDCR_DC_RSVD] && s_axi_rdata[5] == $past(dev_ctrl_q[5]);
  endproperty
  a_rsvd4: assert property (p_rsvd4) else $error("device control read wrong");

  property p_mode;
    ##1 interrupt_signaling_select == $past(dev_ctrl_q[`CDCR_DC_MODE_LSB +: 2]);
  endproperty
  a_mode: assert property (p_mode) else $error("interrupt mode output wrong");

  c_flag: cover property (card_set && flag_clr);
  c_refused: cover property (pwr_refused);
  c_irq: cover property (irq ##[1:4] !irq);

endmodule

`default_nettype wire

// ==== dv/cdcr_card_model.sv ====
// Purpose: Card in the socket, driving its interrupt, ring, speaker and audio lines
// Assumes: Levels requested by the bench, launched from aclk
// Notes:   The controller treats all four lines as asynchronous
`timescale 1ns/1ps
`default_nettype none

module cdcr_card_model
(
  input  wire logic       aclk,
  input  wire logic       irq_req,
  input  wire logic [2:0] lvl,
  output logic            card_func_irq,
  output logic            card_ring_in,
  output logic            card_speaker_in,
  output logic            card_audio_in
);
  // Card lines follow the requested levels
  always_ff @(posedge aclk)
  begin
    card_func_irq <= irq_req;
    {card_ring_in, card_speaker_in, card_audio_in} <= lvl;
  end
endmodule

`default_nettype wire

// ==== dv/card_device_control_regs_tb.sv ====
// Purpose: Self-checking bench of the card/device control bank
// Assumes: 200 MHz aclk, AXI4-Lite master tasks below
// Notes:   Card lines come from cdcr_card_model
`include "cdcr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module card_device_control_regs_tb;
  import cdcr_pkg::*;
  logic          aclk = 1'b0, aresetn = 1'b0, global_reset_n = 1'b0, d3_state = 1'b0;
  logic [11:0]   s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]    s_axi_wstrb = 4'hf, multifunction_terminal_route_code = 4'h8;
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, irq_req = 1'b0;
  logic [2:0]    lvl = 3'h0;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic          card_func_irq, card_ring_in, card_speaker_in, card_audio_in, irq;
  logic          ring_indicate_output, ring_indicate_oe_n, speaker_output_pin;
  logic          speaker_output_oe_n, multifunction_terminal, multifunction_oe_n;
  logic          socket_power_on, low_voltage_capable;
  cdcr_interrupt_signaling_select_t interrupt_signaling_select;
  int            error_cnt = 0, samples_checked = 0, m;

  always #2.5 aclk = ~aclk;

  cdcr_regs u_cdcr_regs (.aclk, .aresetn, .global_reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .card_func_irq, .card_ring_in,
    .card_speaker_in, .card_audio_in, .d3_state, .multifunction_terminal_route_code, .ring_indicate_output,
    .ring_indicate_oe_n, .speaker_output_pin, .speaker_output_oe_n, .multifunction_terminal,
    .multifunction_oe_n, .socket_power_on, .low_voltage_capable, .interrupt_signaling_select,
    .irq);

  cdcr_card_model u_cdcr_card_model (.aclk, .irq_req, .lvl, .card_func_irq, .card_ring_in,
    .card_speaker_in, .card_audio_in);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("BAD time=%0t seen=%h expected=%h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic tmo(input int n);
    if (n >= 50)
    begin
      error_cnt++;
      close_out();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = `CDCR_RESP_OKAY);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    tmo(n);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er = `CDCR_RESP_OKAY);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    tmo(n);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // Ring, speaker and audio pin enables and data
  task automatic pins(input logic [5:0] e);
    cyc(6);
    chk({26'h0, ring_indicate_oe_n, ring_indicate_output, speaker_output_oe_n,
         speaker_output_pin, multifunction_oe_n, multifunction_terminal}, {26'h0, e});
  endtask

  task automatic rst(input logic glob);
    @(posedge aclk);
    aresetn        <= 1'b0;
    global_reset_n <= ~glob;
    repeat (6) @(posedge aclk);
    aresetn        <= 1'b1;
    global_reset_n <= 1'b1;
    cyc(3);
  endtask

  initial
  begin
    rst(1'b1);
    rd(`CDCR_ADDR_CARD_CTRL, 32'h00);
    rd(`CDCR_ADDR_DEV_CTRL, 32'h66);
    chk({30'h0, interrupt_signaling_select}, 32'h3);
    chk({31'h0, low_voltage_capable}, 32'h1);
    pins(6'b101000);
    @(posedge aclk);
    lvl <= 3'b111;
    pins(6'b101001);
    rd(12'h100, 32'h0, `CDCR_RESP_SLVERR);
    wr(12'h100, 32'hff, `CDCR_RESP_SLVERR);
    wr(`CDCR_ADDR_CARD_CTRL, 32'h78);
    rd(`CDCR_ADDR_CARD_CTRL, 32'h78);
    wr(`CDCR_ADDR_CARD_CTRL, 32'hfe);
    pins(6'b010110);
    @(posedge aclk);
    lvl <= 3'b000;
    pins(6'b000010);
    wr(`CDCR_ADDR_CARD_CTRL, 32'h78);
    @(posedge aclk);
    lvl <= 3'b111;
    pins(6'b101001);
    @(posedge aclk);
    multifunction_terminal_route_code <= 4'h0;
    pins(6'b101010);
    @(posedge aclk);
    multifunction_terminal_route_code <= 4'h8;
    // Every interrupt mode, bit 4 ignored
    for (m = 0; m < 4; m++)
    begin
      wr(`CDCR_ADDR_DEV_CTRL, 32'h70 | (m << 1));
      rd(`CDCR_ADDR_DEV_CTRL, 32'h60 | (m << 1));
      cyc(3);
      chk({30'h0, interrupt_signaling_select}, m);
    end
    wr(`CDCR_ADDR_DEV_CTRL, 32'h26);
    cyc(3);
    chk({31'h0, low_voltage_capable}, 32'h0);
    rd(`CDCR_ADDR_DEV_CTRL, 32'h26);
    // Card flag, set beats clear
    wr(`CDCR_ADDR_IRQ_MASK, 32'h1);
    @(posedge aclk);
    irq_req <= 1'b1;
    cyc(6);
    rd(`CDCR_ADDR_CARD_CTRL, 32'h79);
    chk({31'h0, irq}, 32'h1);
    wr(`CDCR_ADDR_CARD_CTRL, 32'h79);
    rd(`CDCR_ADDR_CARD_CTRL, 32'h79);
    @(posedge aclk);
    irq_req <= 1'b0;
    cyc(6);
    wr(`CDCR_ADDR_CARD_CTRL, 32'h78);
    rd(`CDCR_ADDR_CARD_CTRL, 32'h79);
    wr(`CDCR_ADDR_CARD_CTRL, 32'h79);
    rd(`CDCR_ADDR_CARD_CTRL, 32'h78);
    rd(`CDCR_ADDR_IRQ_STAT, 32'h1);
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    // Power lock in D3
    wr(`CDCR_ADDR_DEV_CTRL, 32'he6);
    @(posedge aclk);
    d3_state <= 1'b1;
    wr(`CDCR_ADDR_SKT_PWR, 32'h0);
    cyc(3);
    chk({31'h0, socket_power_on}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(`CDCR_ADDR_IRQ_STAT, 32'h2);
    rd(`CDCR_ADDR_SKT_STAT, 32'h3);
    @(posedge aclk);
    d3_state <= 1'b0;
    wr(`CDCR_ADDR_SKT_PWR, 32'h0);
    cyc(3);
    chk({31'h0, socket_power_on}, 32'h0);
    rd(`CDCR_ADDR_SKT_STAT, 32'h0);
    // Bus reset keeps, global reset clears
    rst(1'b0);
    rd(`CDCR_ADDR_CARD_CTRL, 32'h78);
    rd(`CDCR_ADDR_DEV_CTRL, 32'he6);
    rst(1'b1);
    rd(`CDCR_ADDR_CARD_CTRL, 32'h00);
    rd(`CDCR_ADDR_DEV_CTRL, 32'h66);
    close_out();
  end
endmodule

`default_nettype wire
